/* pclt_cfg.svh */
// Register offsets, field positions, reset values and timing figures of the countdown timer
`ifndef PCLT_CFG_SVH
`define PCLT_CFG_SVH

// Register map, 6-bit register address
`define PCLT_ADDR_W            6
`define PCLT_OFS_MODE          6'h2A
`define PCLT_OFS_PRESCALE_LO   6'h2B
`define PCLT_OFS_RELOAD_HI     6'h2C
`define PCLT_OFS_RELOAD_LO     6'h2D
`define PCLT_OFS_COUNT_HI      6'h2E
`define PCLT_OFS_COUNT_LO      6'h2F

// Reset values
`define PCLT_RST_MODE          8'h00
`define PCLT_RST_PRESCALE_LO   8'h00
`define PCLT_RST_RELOAD        16'h0000
`define PCLT_RST_COUNT         16'h0000
`define PCLT_RDATA_UNMAPPED    8'h00

// Mode register fields
`define PCLT_MODE_PSTART_BIT   7
`define PCLT_MODE_GATE_HI      6
`define PCLT_MODE_GATE_LO      5
`define PCLT_MODE_RELOAD_BIT   4
`define PCLT_MODE_PRE_HI       3
`define PCLT_MODE_PRE_LO       0

// Received bits after which single-receive protocol mode stops the timer
`define PCLT_RX_STOP_BITS      3'h5

// Timer reference and system clock, both in kHz
`define PCLT_CLK_KHZ           250000
`define PCLT_REF_KHZ           13560

`endif

/* pclt_pkg.sv */
// Types shared by the countdown timer modules
package pclt_pkg;

  // Gating source selection
  typedef enum logic [1:0] {
    PCLT_GATE_NONE = 2'h0,
    PCLT_GATE_EXT  = 2'h1,
    PCLT_GATE_AUX  = 2'h2,
    PCLT_GATE_RSVD = 2'h3
  } pclt_gate_t;

  // Timer run state
  typedef enum logic {
    PCLT_IDLE,
    PCLT_RUN
  } pclt_state_t;

endpackage

/* pclt_sync.sv */
// Two-flop synchroniser for a level from an asynchronous pin
`timescale 1ns/1ps
`default_nettype none

module pclt_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output var  logic sync_o
);

  logic meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_o  <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule

`default_nettype wire

/* pclt_prescaler.sv */
// Timer reference generator and odd/even prescaler producing one-cycle timer ticks
`timescale 1ns/1ps
`default_nettype none

`include "pclt_cfg.svh"

module pclt_prescaler #(
  parameter int PRE_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             restart_i,
  input  wire logic             enable_i,
  input  wire logic             even_i,
  input  wire logic [PRE_W-1:0] prescale_i,
  output var  logic             tick_o
);

  localparam logic [17:0] REF_STEP = 18'(`PCLT_REF_KHZ);
  localparam logic [17:0] REF_WRAP = 18'(`PCLT_CLK_KHZ);

  logic [17:0]    phase_ff;
  logic [18:0]    phase_sum;
  logic           ref_en_ff;
  logic [PRE_W:0] div_cnt_ff;
  logic [PRE_W:0] div_last;

  // One extra bit so the sum near the wrap point cannot overflow the compare
  assign phase_sum = {1'b0, phase_ff} + {1'b0, REF_STEP};

  // Fractional accumulator: average rate of ref_en_ff is the reference frequency
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff  <= 18'h0_0000;
      ref_en_ff <= 1'b0;
    end else if (phase_sum >= {1'b0, REF_WRAP}) begin
      phase_ff  <= 18'(phase_sum - {1'b0, REF_WRAP});
      ref_en_ff <= 1'b1;
    end else begin
      phase_ff  <= phase_sum[17:0];
      ref_en_ff <= 1'b0;
    end
  end

  // Divisor minus one: 2P for odd mode, 2P+1 for even mode
  assign div_last = {prescale_i, even_i};

  // Count reference pulses; tick when the divisor is reached
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      div_cnt_ff <= '0;
      tick_o     <= 1'b0;
    end else if (enable_i && ref_en_ff) begin
      if (div_cnt_ff >= div_last) begin
        div_cnt_ff <= '0;
        tick_o     <= 1'b1;
      end else begin
        div_cnt_ff <= div_cnt_ff + 1'b1;
        tick_o     <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* pclt_timer.sv */
// Protocol-linked countdown timer: registers, start/stop control, gating and down-counter
//
// What this block does
// - Protocol start set: every transmission end starts the timer.
// - Protocol start, single receive: stop after the fifth received bit.
// - Protocol start, multi receive: received bits never halt it; the stop command or expiry does.
// - Protocol start clear: transmit and receive events leave the timer alone.
// - Gating field: 00 free, 01 external pin, 10 auxiliary pin, 11 undefined.
// - Gated: running flag shows gate enable; flag never feeds the gate.
// - Auto reload set: reload from reload value and keep counting.
// - Auto reload clear: count to zero, then raise expiry interrupt.
// - Prescaler is mode bits 3..0 above the 8-bit low register.
// - Even option 0: tick = reference / (2*prescaler + 1).
// - Even option 1: tick = reference / (2*prescaler + 2).
// - Reload value held in high and low 8-bit read-write registers.
// - Each start copies the 16-bit reload value into the counter.
// - Reload writes take effect at the next start or auto reload, never mid-count.
// - Counter value readable as two 8-bit registers.
// - Counter high byte read-only at 2Eh, low byte at 2Fh.
`timescale 1ns/1ps
`default_nettype none

`include "pclt_cfg.svh"

module pclt_timer
  import pclt_pkg::*;
#(
  parameter int PRE_W = 12,
  parameter int CNT_W = 16
) (
  input  wire logic                    CLK_I,
  input  wire logic                    SYS_RST_I,
  // Register port
  input  wire logic [`PCLT_ADDR_W-1:0] REG_ADDR_I,
  input  wire logic                    REG_WR_I,
  input  wire logic [7:0]              REG_WDATA_I,
  input  wire logic                    REG_RD_I,
  output var  logic [7:0]              REG_RDATA_O,
  // Control bits held in neighbouring units
  input  wire logic                    EVEN_PRESCALE_OPTION_I,
  input  wire logic                    MULTI_FRAME_RECEIVE_I,
  input  wire logic                    TIMER_STOP_COMMAND_I,
  input  wire logic                    TIMER_START_COMMAND_I,
  // Protocol events, same clock
  input  wire logic                    TX_DONE_I,
  input  wire logic                    RX_BIT_I,
  // Gate pins, asynchronous
  input  wire logic                    EXTERNAL_GATE_INPUT_I,
  input  wire logic                    AUXILIARY_PIN_ONE_I,
  // Status
  output var  logic                    TIMER_RUNNING_FLAG_O,
  output var  logic                    TIMER_EXPIRED_IRQ_O
);

  // Configuration registers
  logic [7:0]       mode_ff;
  logic [7:0]       prescale_lo_ff;
  logic [CNT_W-1:0] reload_ff;

  // Timer state
  pclt_state_t      state_ff;
  logic [CNT_W-1:0] count_ff;
  logic [2:0]       rx_bits_ff;

  // Decoded fields
  logic             protocol_start_enable;
  pclt_gate_t       gating_select;
  logic             auto_reload_enable;
  logic [PRE_W-1:0] prescale_value;

  // Synchronised pins and derived controls
  logic             ext_gate_s;
  logic             aux_gate_s;
  logic             gate_open;
  logic             start_evt;
  logic             rx_stop_evt;
  logic             stop_evt;
  logic             tick;
  logic             count_en;
  logic             nxt_running;

  assign protocol_start_enable = mode_ff[`PCLT_MODE_PSTART_BIT];
  assign gating_select         = pclt_gate_t'(mode_ff[`PCLT_MODE_GATE_HI:`PCLT_MODE_GATE_LO]);
  assign auto_reload_enable    = mode_ff[`PCLT_MODE_RELOAD_BIT];
  // Upper nibble from the mode register, lower byte from its own register
  assign prescale_value = {mode_ff[`PCLT_MODE_PRE_HI:`PCLT_MODE_PRE_LO], prescale_lo_ff};

  // Gate pins come from outside the clock domain
  pclt_sync u_sync_ext (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i (EXTERNAL_GATE_INPUT_I),
    .sync_o  (ext_gate_s)
  );

  pclt_sync u_sync_aux (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i (AUXILIARY_PIN_ONE_I),
    .sync_o  (aux_gate_s)
  );

  // Gate decode; the undefined code is treated as ungated so the timer cannot hang
  always_comb begin
    unique case (gating_select)
      PCLT_GATE_NONE: gate_open = 1'b1;
      PCLT_GATE_EXT:  gate_open = ext_gate_s;
      PCLT_GATE_AUX:  gate_open = aux_gate_s;
      PCLT_GATE_RSVD: gate_open = 1'b1;
    endcase
  end

  // Start: software command, or transmission end only with protocol start set
  assign start_evt = TIMER_START_COMMAND_I | (protocol_start_enable & TX_DONE_I);

  // Fifth received bit stops the timer only in single-receive protocol mode
  assign rx_stop_evt = protocol_start_enable & ~MULTI_FRAME_RECEIVE_I & RX_BIT_I
                     & (rx_bits_ff == `PCLT_RX_STOP_BITS - 3'h1) & (state_ff == PCLT_RUN);

  // Stop command always halts, and wins over a start in the same cycle
  assign stop_evt = TIMER_STOP_COMMAND_I | rx_stop_evt;

  // Prescaler runs only while counting is allowed
  assign count_en = (state_ff == PCLT_RUN) & gate_open;

  pclt_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .clk_i      (CLK_I),
    .rst_i      (SYS_RST_I),
    .restart_i  (start_evt),
    .enable_i   (count_en),
    .even_i     (EVEN_PRESCALE_OPTION_I),
    .prescale_i (prescale_value),
    .tick_o     (tick)
  );

  // Register writes; reset leaves every field at zero
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_ff        <= `PCLT_RST_MODE;
      prescale_lo_ff <= `PCLT_RST_PRESCALE_LO;
      reload_ff      <= `PCLT_RST_RELOAD;
    end else if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        `PCLT_OFS_MODE:        mode_ff <= REG_WDATA_I;
        `PCLT_OFS_PRESCALE_LO: prescale_lo_ff <= REG_WDATA_I;
        `PCLT_OFS_RELOAD_HI:   reload_ff[CNT_W-1:8] <= REG_WDATA_I;
        `PCLT_OFS_RELOAD_LO:   reload_ff[7:0] <= REG_WDATA_I;
        default: ;  // Counter bytes are read-only; other offsets ignored
      endcase
    end
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= `PCLT_RDATA_UNMAPPED;
    end else if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        `PCLT_OFS_MODE:        REG_RDATA_O <= mode_ff;
        `PCLT_OFS_PRESCALE_LO: REG_RDATA_O <= prescale_lo_ff;
        `PCLT_OFS_RELOAD_HI:   REG_RDATA_O <= reload_ff[CNT_W-1:8];
        `PCLT_OFS_RELOAD_LO:   REG_RDATA_O <= reload_ff[7:0];
        `PCLT_OFS_COUNT_HI:    REG_RDATA_O <= count_ff[CNT_W-1:8];
        `PCLT_OFS_COUNT_LO:    REG_RDATA_O <= count_ff[7:0];
        default:               REG_RDATA_O <= `PCLT_RDATA_UNMAPPED;
      endcase
    end
  end

  // Run state; zero with auto reload clear ends the run
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_ff <= PCLT_IDLE;
    end else if (stop_evt) begin
      state_ff <= PCLT_IDLE;
    end else if (start_evt) begin
      state_ff <= PCLT_RUN;
    end else if (state_ff == PCLT_RUN && tick && count_ff == '0 && !auto_reload_enable) begin
      state_ff <= PCLT_IDLE;
    end
  end

  // Received-bit counter, cleared at each start so every frame counts afresh
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || start_evt) begin
      rx_bits_ff <= 3'h0;
    end else if (RX_BIT_I && state_ff == PCLT_RUN && rx_bits_ff != `PCLT_RX_STOP_BITS) begin
      rx_bits_ff <= rx_bits_ff + 3'h1;
    end
  end

  // Down-counter; reload register is only sampled at a start or on auto reload
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      count_ff <= `PCLT_RST_COUNT;
    end else if (stop_evt) begin
      count_ff <= count_ff;  // Halt freezes the value for software to read
    end else if (start_evt) begin
      count_ff <= reload_ff;
    end else if (state_ff == PCLT_RUN && tick) begin
      if (count_ff == '0) begin
        if (auto_reload_enable) begin
          count_ff <= reload_ff;
        end
      end else begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Expiry pulse; the interrupt flag register itself lives in the interrupt unit
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      TIMER_EXPIRED_IRQ_O <= 1'b0;
    end else begin
      TIMER_EXPIRED_IRQ_O <= ~stop_evt & ~start_evt & (state_ff == PCLT_RUN) & tick
                           & (count_ff == '0) & ~auto_reload_enable;
    end
  end

  // Running flag: in gated mode it follows the gate; it is never fed back to the gate
  assign nxt_running = (state_ff == PCLT_RUN) & gate_open;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      TIMER_RUNNING_FLAG_O <= 1'b0;
    end else begin
      TIMER_RUNNING_FLAG_O <= nxt_running;
    end
  end

endmodule

`default_nettype wire

/* pclt_timer_sva.sv */
// Port-level assertions for the protocol-linked countdown timer
`timescale 1ns/1ps
`default_nettype none
`include "pclt_cfg.svh"
module pclt_timer_sva (
  input wire logic                    CLK_I,
  input wire logic                    SYS_RST_I,
  input wire logic [`PCLT_ADDR_W-1:0] REG_ADDR_I,
  input wire logic                    REG_WR_I,
  input wire logic [7:0]              REG_WDATA_I,
  input wire logic                    REG_RD_I,
  input wire logic [7:0]              REG_RDATA_O,
  input wire logic                    TIMER_STOP_COMMAND_I,
  input wire logic                    TIMER_START_COMMAND_I,
  input wire logic                    TX_DONE_I,
  input wire logic                    RX_BIT_I,
  input wire logic                    EXTERNAL_GATE_INPUT_I,
  input wire logic                    AUXILIARY_PIN_ONE_I,
  input wire logic                    TIMER_RUNNING_FLAG_O,
  input wire logic                    TIMER_EXPIRED_IRQ_O
);
  logic [7:0] mode_ff, pre_ff, rhi_ff, rlo_ff, exp_rd;
  // Shadow of the writable registers, rebuilt from port writes
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode_ff <= 8'h00;
      pre_ff  <= 8'h00;
      rhi_ff  <= 8'h00;
      rlo_ff  <= 8'h00;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == `PCLT_OFS_MODE) mode_ff <= REG_WDATA_I;
      if (REG_ADDR_I == `PCLT_OFS_PRESCALE_LO) pre_ff <= REG_WDATA_I;
      if (REG_ADDR_I == `PCLT_OFS_RELOAD_HI) rhi_ff <= REG_WDATA_I;
      if (REG_ADDR_I == `PCLT_OFS_RELOAD_LO) rlo_ff <= REG_WDATA_I;
    end
  end
  // Expected read-back of the writable registers
  always_comb begin
    exp_rd = (REG_ADDR_I == `PCLT_OFS_MODE) ? mode_ff : (REG_ADDR_I == `PCLT_OFS_PRESCALE_LO) ? pre_ff :
             (REG_ADDR_I == `PCLT_OFS_RELOAD_HI) ? rhi_ff : rlo_ff;
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_rdata_holds: assert property (!$past(REG_RD_I) |-> $stable(REG_RDATA_O)) else $error("read data moved");
  a_rd_config: assert property (REG_RD_I && !REG_WR_I && REG_ADDR_I inside {[6'h2A:6'h2D]}
    |=> REG_RDATA_O == $past(exp_rd)) else $error("config read-back wrong");
  a_rd_unmapped: assert property (REG_RD_I && !(REG_ADDR_I inside {[6'h2A:6'h2F]})
    |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
  a_irq_pulse: assert property (TIMER_EXPIRED_IRQ_O |=> !TIMER_EXPIRED_IRQ_O) else $error("irq too long");
  a_irq_idles: assert property (TIMER_EXPIRED_IRQ_O && !TIMER_START_COMMAND_I && !TX_DONE_I
    |=> !TIMER_RUNNING_FLAG_O) else $error("timer runs after expiry");
  a_reload_quiet: assert property (mode_ff[4] && $past(mode_ff[4]) |-> !TIMER_EXPIRED_IRQ_O)
    else $error("irq with auto reload");
  a_stop_halts: assert property (TIMER_STOP_COMMAND_I ##1 (!TIMER_START_COMMAND_I && !TX_DONE_I)[*2]
    |-> !TIMER_RUNNING_FLAG_O) else $error("stop ignored");
  a_start_runs: assert property (TIMER_START_COMMAND_I && !TIMER_STOP_COMMAND_I && mode_ff[6:5] == 2'h0
    |=> ##1 TIMER_RUNNING_FLAG_O) else $error("start not seen");
  a_pstart_off: assert property ((!TIMER_START_COMMAND_I && !mode_ff[7] && mode_ff[6:5] == 2'h0
    && !TIMER_RUNNING_FLAG_O)[*4] |=> !TIMER_RUNNING_FLAG_O) else $error("started without command");
  a_gate_shut: assert property (((mode_ff[6:5] == 2'h1 && !EXTERNAL_GATE_INPUT_I) ||
    (mode_ff[6:5] == 2'h2 && !AUXILIARY_PIN_ONE_I))[*5] |-> !TIMER_RUNNING_FLAG_O) else $error("gate ignored");
  c_expire: cover property ($rose(TIMER_EXPIRED_IRQ_O));
  c_rx_stop: cover property (mode_ff[7] && RX_BIT_I && TIMER_RUNNING_FLAG_O);
  c_stop: cover property (TIMER_STOP_COMMAND_I && TIMER_RUNNING_FLAG_O);
endmodule
bind pclt_timer pclt_timer_sva i_pclt_timer_sva (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .TIMER_STOP_COMMAND_I(TIMER_STOP_COMMAND_I), .TIMER_START_COMMAND_I(TIMER_START_COMMAND_I),
  .TX_DONE_I(TX_DONE_I), .RX_BIT_I(RX_BIT_I), .EXTERNAL_GATE_INPUT_I(EXTERNAL_GATE_INPUT_I),
  .AUXILIARY_PIN_ONE_I(AUXILIARY_PIN_ONE_I), .TIMER_RUNNING_FLAG_O(TIMER_RUNNING_FLAG_O),
  .TIMER_EXPIRED_IRQ_O(TIMER_EXPIRED_IRQ_O));
`default_nettype wire

/* pclt_timer_tb.sv */
// Self-checking testbench for the protocol-linked countdown timer
`timescale 1ns/1ps
`default_nettype none
`include "pclt_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pclt_timer_tb;
  logic       clk, rst, wr, rd, even, multi, stop, start, tx, rx, ext, aux, run_f, irq;
  logic [5:0] addr;
  logic [7:0] wdata, rdata;
  int         fails, tests_run;
  pclt_timer i_pclt_timer (.CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .EVEN_PRESCALE_OPTION_I(even), .MULTI_FRAME_RECEIVE_I(multi),
    .TIMER_STOP_COMMAND_I(stop), .TIMER_START_COMMAND_I(start), .TX_DONE_I(tx), .RX_BIT_I(rx),
    .EXTERNAL_GATE_INPUT_I(ext), .AUXILIARY_PIN_ONE_I(aux), .TIMER_RUNNING_FLAG_O(run_f),
    .TIMER_EXPIRED_IRQ_O(irq));
  // 250 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Register writes and reads, one strobe cycle each
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk); addr = a; wdata = d; wr = 1'b1;
    @(negedge clk); wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk); addr = a; rd = 1'b1;
    @(negedge clk); rd = 1'b0;
    @(negedge clk); `CHK(rdata, e)
  endtask
  // One-cycle pulse on {start, stop, tx, rx}
  task automatic pulse(input logic [3:0] m);
    @(negedge clk); {start, stop, tx, rx} = m;
    @(negedge clk); {start, stop, tx, rx} = 4'h0;
  endtask
  // Flag is judged after sync and register lag has passed
  task automatic flag_chk(input logic e);
    repeat (5) @(negedge clk);
    `CHK(run_f, e)
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rd_chk(6'h2A + i[5:0], 8'h00);
    rd_chk(6'h10, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) wr_reg(6'h2A + i[5:0], 8'h50 + i[7:0]);
    for (int i = 0; i < 4; i++) rd_chk(6'h2A + i[5:0], 8'h50 + i[7:0]);
    wr_reg(6'h2E, 8'hFF);
    rd_chk(6'h2E, 8'h00);
    $display("t_regs done");
  endtask
  // Huge prescaler keeps the count still while it is read
  task automatic t_hold();
    wr_reg(6'h2A, 8'h0F); wr_reg(6'h2B, 8'hFF); wr_reg(6'h2C, 8'h12); wr_reg(6'h2D, 8'h34);
    pulse(4'h8);
    rd_chk(6'h2E, 8'h12); rd_chk(6'h2F, 8'h34);
    wr_reg(6'h2C, 8'h56); wr_reg(6'h2D, 8'h78);
    rd_chk(6'h2E, 8'h12);
    pulse(4'h8);
    rd_chk(6'h2E, 8'h56); rd_chk(6'h2F, 8'h78);
    pulse(4'h4); flag_chk(1'b0);
    $display("t_hold done");
  endtask
  task automatic t_proto();
    wr_reg(6'h2A, 8'h8F); multi = 1'b0;
    pulse(4'h2); flag_chk(1'b1);
    repeat (4) pulse(4'h1);
    flag_chk(1'b1);
    pulse(4'h1); flag_chk(1'b0);
    multi = 1'b1; pulse(4'h2);
    repeat (6) pulse(4'h1);
    flag_chk(1'b1);
    pulse(4'h4); flag_chk(1'b0);
    wr_reg(6'h2A, 8'h0F); pulse(4'h2); flag_chk(1'b0);
    pulse(4'h8);
    repeat (5) pulse(4'h1);
    flag_chk(1'b1);
    pulse(4'h4); multi = 1'b0;
    $display("t_proto done");
  endtask
  task automatic t_gate();
    wr_reg(6'h2A, 8'h2F); ext = 1'b0; pulse(4'h8); flag_chk(1'b0);
    ext = 1'b1; flag_chk(1'b1);
    wr_reg(6'h2A, 8'h4F); aux = 1'b0; flag_chk(1'b0);
    aux = 1'b1; flag_chk(1'b1);
    pulse(4'h4);
    $display("t_gate done");
  endtask
  // Start to expiry time against (reload+1) ticks of the prescaled reference
  task automatic t_time(input logic [3:0] hi, input logic [7:0] lo, input logic ev, input logic [7:0] rld);
    int n, exp_n;
    exp_n = (rld + 1) * (2 * {hi, lo} + 1 + ev) * `PCLT_CLK_KHZ / `PCLT_REF_KHZ;
    wr_reg(6'h2A, {4'h0, hi}); wr_reg(6'h2B, lo); wr_reg(6'h2C, 8'h00); wr_reg(6'h2D, rld);
    even = ev; n = 0;
    pulse(4'h8);
    while (irq !== 1'b1 && n < 20000) begin @(negedge clk); n++; end
    `CHK(n > exp_n - 20 && n < exp_n + 20, 1'b1)
    rd_chk(6'h2F, 8'h00);
    even = 1'b0;
    $display("t_time done, %0d cycles", n);
  endtask
  task automatic t_auto();
    logic seen;
    seen = 1'b0;
    wr_reg(6'h2A, 8'h10); wr_reg(6'h2B, 8'h00); wr_reg(6'h2C, 8'h00); wr_reg(6'h2D, 8'h01);
    pulse(4'h8);
    repeat (300) begin @(negedge clk); if (irq === 1'b1) seen = 1'b1; end
    `CHK(seen, 1'b0)
    `CHK(run_f, 1'b1)
    pulse(4'h4);
    $display("t_auto done");
  endtask
  // Hang guard: the slowest run needs about 9500 cycles
  initial begin
    #200000;
    fails++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd, even, multi, stop, start, tx, rx, ext, aux} = 11'h400;
    addr = 6'h00; wdata = 8'h00; fails = 0; tests_run = 0;
    repeat (20) @(posedge clk);
    @(negedge clk); rst = 1'b0;
    t_reset(); t_regs(); t_hold(); t_proto(); t_gate();
    t_time(4'h0, 8'h01, 1'b0, 8'h03);
    t_time(4'h0, 8'h01, 1'b1, 8'h03);
    t_time(4'h1, 8'h01, 1'b0, 8'h00);
    t_auto();
    tally_and_finish();
  end
endmodule
`default_nettype wire
